// file: common/dst_map.vh
// constants and bit-cycle timing for the debug serial time-out and step block
// Function
// - single step runs exactly one user instruction
// - pending interrupt: stack only, no instruction
// - stepped stop/wait holds step unfinished
// - in stepped stop/wait all commands but enter-debug work
// - system stop blocks every debug command
// - leaving stop/wait enters debug mode at vector
// - no acknowledge for step over stop/wait
// - commands during/after stop/wait still acknowledge
// - handshake enable cleared by system stop or ack-disable command
// - low over 128 cycles is speed probe
// - probe waits for rising edge, no time-out
// - short low pulse counts as one bit
// - 512 cycles without falling edge mid-transfer soft-resets
// - handshake off: unfetched read dropped after 512
// - handshake on: time-out paused awaiting read data
// - acknowledge re-arms 512-cycle read time-out
// - after soft-reset next fall starts anew
// - handshake disabled after NRST reset, kept over soft-reset
// - probe reply: wait high, 16, low 128, speedup
`ifndef DST_MAP_VH
`define DST_MAP_VH
`define DST_PROBE_CYC     16'h0080
`define DST_TIMEOUT_CYC   16'h0200
`define DST_REPLY_DLY     16'h0010
`define DST_REPLY_LOW     16'h0080
`define DST_CNT_ONE       16'h0001
`define DST_CNT_ZERO      16'h0000
`endif

// file: design/dst_debug_serial.v
// debug serial link time-out, speed probe, handshake and single-step control
`timescale 1ns/1ps
`include "dst_map.vh"
module dst_debug_serial #(
  parameter CNT_W = 16
) (
  // clock, reset, enable
  input  wire CORE_CLK,
  input  wire NRST,
  input  wire CE,
  // debug serial pin (oe low while driving)
  input  wire DEBUG_SERIAL_PIN_I,
  output reg  DEBUG_SERIAL_PIN_O,
  output reg  DEBUG_SERIAL_PIN_OE_N,
  // bit receiver status
  output reg  BIT_STROBE,
  output reg  BIT_VALUE,
  output reg  SOFT_RESET,
  output reg  PROBE_SEEN,
  // command decoder side
  input  wire CMD_PARTIAL,
  input  wire CMD_VALID,
  input  wire CMD_IS_ENTER_DEBUG,
  input  wire CMD_IS_STEP,
  input  wire CMD_IS_ACK_ENABLE,
  input  wire CMD_IS_ACK_DISABLE,
  input  wire CMD_IS_READ,
  input  wire READ_DATA_FETCHED,
  input  wire ACK_ISSUED,
  output reg  CMD_EXEC,
  output reg  ACK_REQ,
  output reg  HANDSHAKE_EN,
  // cpu side
  input  wire DEBUG_MODE_ACTIVE,
  input  wire IRQ_PENDING,
  input  wire CPU_LOW_POWER,
  input  wire SYSTEM_STOP,
  input  wire INSTR_DONE,
  input  wire STACKING_DONE,
  output reg  RUN_ONE_INSTR,
  output reg  DO_STACKING,
  output reg  ENTER_DEBUG_MODE,
  output reg  STEP_PENDING
);
  wire pin_lvl;
  reg  pin_last_q;
  wire fall = pin_last_q & ~pin_lvl;
  wire rise = ~pin_last_q & pin_lvl;

  dst_pin_sync u_sync (
    .CORE_CLK (CORE_CLK),
    .NRST     (NRST),
    .CE       (CE),
    .PIN_IN   (DEBUG_SERIAL_PIN_I),
    .PIN_LVL  (pin_lvl)
  );

  function [CNT_W-1:0] inc;
    input [CNT_W-1:0] v;
    begin
      inc = v + `DST_CNT_ONE;
    end
  endfunction

  // receive / probe states
  localparam [4:0] RX_IDLE  = 5'h01;
  localparam [4:0] RX_LOW   = 5'h02;
  localparam [4:0] RX_PROBE = 5'h04;
  localparam [4:0] RX_DLY   = 5'h08;
  localparam [4:0] RX_REPLY = 5'h10;
  reg [4:0]       rx_q;
  reg [CNT_W-1:0] low_cnt_q;
  reg [CNT_W-1:0] to_cnt_q;
  reg             speedup_q;
  reg             read_wait_q;
  reg             read_armed_q;

  // step states
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_RUN   = 4'h2;
  localparam [3:0] ST_STACK = 4'h4;
  localparam [3:0] ST_LOWP  = 4'h8;
  reg [3:0] st_q;
  reg       step_noack_q;
  reg       step_ack;

  wire transfer_open = CMD_PARTIAL | read_armed_q;
  wire to_paused     = read_wait_q & HANDSHAKE_EN;
  wire timeout       = transfer_open & ~to_paused &
                       (to_cnt_q >= `DST_TIMEOUT_CYC - `DST_CNT_ONE);
  // hardware commands stay live in cpu stop/wait except enter-debug while a step is pending, none in system stop
  wire cmd_ok = CMD_VALID & ~SYSTEM_STOP &
                ~(CMD_IS_ENTER_DEBUG & CPU_LOW_POWER & STEP_PENDING);

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      pin_last_q            <= 1'b1;
      rx_q                  <= RX_IDLE;
      low_cnt_q             <= `DST_CNT_ZERO;
      to_cnt_q              <= `DST_CNT_ZERO;
      speedup_q             <= 1'b0;
      read_wait_q           <= 1'b0;
      read_armed_q          <= 1'b0;
      DEBUG_SERIAL_PIN_O    <= 1'b1;
      DEBUG_SERIAL_PIN_OE_N <= 1'b1;
      BIT_STROBE            <= 1'b0;
      BIT_VALUE             <= 1'b0;
      SOFT_RESET            <= 1'b0;
      PROBE_SEEN            <= 1'b0;
      HANDSHAKE_EN          <= 1'b0;
      CMD_EXEC              <= 1'b0;
      ACK_REQ               <= 1'b0;
    end else if (CE) begin
      pin_last_q <= pin_lvl;
      BIT_STROBE <= 1'b0;
      SOFT_RESET <= 1'b0;
      PROBE_SEEN <= 1'b0;
      CMD_EXEC   <= 1'b0;
      ACK_REQ    <= 1'b0;
      // time-out counter
      // a soft-reset restarts the count so a held partial flag fires again 512 cycles later
      if (fall || timeout || !transfer_open || to_paused)
        to_cnt_q <= `DST_CNT_ZERO;
      else
        to_cnt_q <= inc(to_cnt_q);
      if (timeout) begin
        SOFT_RESET   <= 1'b1;
        read_wait_q  <= 1'b0;
        read_armed_q <= 1'b0;
      end
      // accepted command side effects
      if (cmd_ok) begin
        CMD_EXEC <= 1'b1;
        if (CMD_IS_ACK_ENABLE)
          HANDSHAKE_EN <= 1'b1;
        else if (CMD_IS_ACK_DISABLE)
          HANDSHAKE_EN <= 1'b0;
        if (CMD_IS_READ) begin
          read_wait_q  <= 1'b1;
          read_armed_q <= 1'b1;
        end
        // step ack is deferred to the step machine
        if ((HANDSHAKE_EN || CMD_IS_ACK_ENABLE) && !CMD_IS_STEP && !CMD_IS_READ)
          ACK_REQ <= 1'b1;
      end
      if (read_wait_q && HANDSHAKE_EN && ACK_ISSUED) begin
        read_wait_q <= 1'b0;
        to_cnt_q    <= `DST_CNT_ZERO;
      end
      if (READ_DATA_FETCHED) begin
        read_wait_q  <= 1'b0;
        read_armed_q <= 1'b0;
      end
      if (SYSTEM_STOP)
        HANDSHAKE_EN <= 1'b0;
      if (step_ack)
        ACK_REQ <= 1'b1;
      // bit reception and speed probe
      case (rx_q)
        RX_IDLE: begin
          DEBUG_SERIAL_PIN_OE_N <= 1'b1;
          if (fall) begin
            rx_q      <= RX_LOW;
            low_cnt_q <= `DST_CNT_ZERO;
          end
        end
        RX_LOW: begin
          low_cnt_q <= inc(low_cnt_q);
          if (pin_lvl) begin
            rx_q       <= RX_IDLE;
            BIT_STROBE <= 1'b1;
            BIT_VALUE  <= 1'b1;
          end else if (low_cnt_q >= `DST_PROBE_CYC) begin
            rx_q         <= RX_PROBE;
            PROBE_SEEN   <= 1'b1;
            SOFT_RESET   <= 1'b1;
            read_wait_q  <= 1'b0;
            read_armed_q <= 1'b0;
          end
        end
        RX_PROBE: begin
          if (rise) begin
            rx_q      <= RX_DLY;
            low_cnt_q <= `DST_CNT_ZERO;
          end
        end
        RX_DLY: begin
          low_cnt_q <= inc(low_cnt_q);
          if (low_cnt_q >= `DST_REPLY_DLY - `DST_CNT_ONE) begin
            rx_q                  <= RX_REPLY;
            low_cnt_q             <= `DST_CNT_ZERO;
            DEBUG_SERIAL_PIN_O    <= 1'b0;
            DEBUG_SERIAL_PIN_OE_N <= 1'b0;
          end
        end
        RX_REPLY: begin
          if (speedup_q) begin
            speedup_q             <= 1'b0;
            DEBUG_SERIAL_PIN_OE_N <= 1'b1;
            rx_q                  <= RX_IDLE;
          end else begin
            low_cnt_q <= inc(low_cnt_q);
            if (low_cnt_q >= `DST_REPLY_LOW - `DST_CNT_ONE) begin
              speedup_q          <= 1'b1;
              DEBUG_SERIAL_PIN_O <= 1'b1;
            end
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // single step control
  always @* begin
    step_ack = 1'b0;
    if (HANDSHAKE_EN && !step_noack_q &&
        ((st_q == ST_RUN && INSTR_DONE && !CPU_LOW_POWER) ||
         (st_q == ST_STACK && STACKING_DONE)))
      step_ack = 1'b1;
  end

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      st_q             <= ST_IDLE;
      step_noack_q     <= 1'b0;
      RUN_ONE_INSTR    <= 1'b0;
      DO_STACKING      <= 1'b0;
      ENTER_DEBUG_MODE <= 1'b0;
      STEP_PENDING     <= 1'b0;
    end else if (CE) begin
      RUN_ONE_INSTR    <= 1'b0;
      DO_STACKING      <= 1'b0;
      ENTER_DEBUG_MODE <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_ok && CMD_IS_STEP && DEBUG_MODE_ACTIVE) begin
            STEP_PENDING <= 1'b1;
            step_noack_q <= 1'b0;
            if (IRQ_PENDING) begin
              st_q        <= ST_STACK;
              DO_STACKING <= 1'b1;
            end else begin
              st_q          <= ST_RUN;
              RUN_ONE_INSTR <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (CPU_LOW_POWER) begin
            st_q         <= ST_LOWP;
            step_noack_q <= 1'b1;
          end else if (INSTR_DONE) begin
            st_q             <= ST_IDLE;
            ENTER_DEBUG_MODE <= 1'b1;
            STEP_PENDING     <= 1'b0;
          end
        end
        ST_STACK: begin
          if (STACKING_DONE) begin
            st_q             <= ST_IDLE;
            ENTER_DEBUG_MODE <= 1'b1;
            STEP_PENDING     <= 1'b0;
          end
        end
        ST_LOWP: begin
          if (!CPU_LOW_POWER && STACKING_DONE) begin
            st_q             <= ST_IDLE;
            ENTER_DEBUG_MODE <= 1'b1;
            STEP_PENDING     <= 1'b0;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // dst_debug_serial

// file: design/dst_pin_sync.v
// three-stage synchroniser for the debug serial pin with change agreement
`timescale 1ns/1ps
module dst_pin_sync (
  // clock and reset
  input  wire CORE_CLK,
  input  wire NRST,
  input  wire CE,
  // pin in and filtered level out
  input  wire PIN_IN,
  output reg  PIN_LVL
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      PIN_LVL <= 1'b1;
    end else if (CE) begin
      s1_q <= PIN_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // level changes only when the two later stages agree
      if (s2_q == s3_q)
        PIN_LVL <= s3_q;
    end
  end
endmodule // dst_pin_sync

// file: testbench/dst_host_pod.sv
// host pod model: pulls the debug serial pin low on request, else the target drive or pull-up sets it
`timescale 1ns/1ps
module dst_host_pod (
  // host request
  input  wire tx_low,
  // target drive
  input  wire oe_n,
  input  wire drv,
  // resolved pin
  output wire pin
);
  // wired level: any low driver wins, a released pin floats high
  assign pin = (oe_n | drv) & ~tx_low;
endmodule // dst_host_pod

// file: testbench/dst_monitor_monitor.sv
// assertion checker on the ports of the debug serial time-out and step block
`timescale 1ns/1ps
module dst_monitor (
  // clock, reset, pin
  input wire CORE_CLK,
  input wire NRST,
  input wire DEBUG_SERIAL_PIN_I,
  input wire DEBUG_SERIAL_PIN_O,
  input wire DEBUG_SERIAL_PIN_OE_N,
  input wire PROBE_SEEN,
  input wire SOFT_RESET,
  // command side
  input wire CMD_VALID,
  input wire CMD_IS_ENTER_DEBUG,
  input wire CMD_IS_STEP,
  input wire CMD_IS_READ,
  input wire CMD_IS_ACK_DISABLE,
  input wire CMD_EXEC,
  input wire ACK_REQ,
  input wire HANDSHAKE_EN,
  // cpu side
  input wire SYSTEM_STOP,
  input wire DEBUG_MODE_ACTIVE,
  input wire IRQ_PENDING,
  input wire RUN_ONE_INSTR,
  input wire DO_STACKING
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic [15:0] drv_cnt_q;
  logic [15:0] idle_cnt_q;
  logic        pin_prev_q;
  // cycles the pin has been driven, and cycles since the last raw falling edge
  always_ff @(posedge CORE_CLK) begin
    pin_prev_q <= DEBUG_SERIAL_PIN_I;
    if (!NRST || DEBUG_SERIAL_PIN_OE_N)
      drv_cnt_q <= 16'h0000;
    else
      drv_cnt_q <= drv_cnt_q + 16'h0001;
    if (!NRST || (pin_prev_q && !DEBUG_SERIAL_PIN_I))
      idle_cnt_q <= 16'h0000;
    else if (idle_cnt_q != 16'hFFFF)
      idle_cnt_q <= idle_cnt_q + 16'h0001;
  end
  a_step_one_instr:
    assert property (CMD_VALID && CMD_IS_STEP && DEBUG_MODE_ACTIVE && !IRQ_PENDING && !SYSTEM_STOP
      |=> RUN_ONE_INSTR && !DO_STACKING) else $error("step did not run one instruction");
  a_irq_stack_only:
    assert property (CMD_VALID && CMD_IS_STEP && DEBUG_MODE_ACTIVE && IRQ_PENDING && !SYSTEM_STOP
      |=> DO_STACKING && !RUN_ONE_INSTR) else $error("pending interrupt not stacked alone");
  a_cmd_live:
    assert property (CMD_VALID && !SYSTEM_STOP && !CMD_IS_ENTER_DEBUG |=> CMD_EXEC)
      else $error("command not executed");
  a_stop_blocks_cmd:
    assert property (CMD_VALID && SYSTEM_STOP |=> !CMD_EXEC) else $error("command ran in system stop");
  a_cmd_gets_ack:
    assert property (CMD_VALID && HANDSHAKE_EN && !SYSTEM_STOP && !CMD_IS_STEP && !CMD_IS_READ
      && !CMD_IS_ENTER_DEBUG && !CMD_IS_ACK_DISABLE |=> ACK_REQ) else $error("missing ack request");
  a_stop_clears_hs:
    assert property (SYSTEM_STOP |=> !HANDSHAKE_EN) else $error("handshake kept in system stop");
  a_probe_long_low:
    assert property (PROBE_SEEN |-> SOFT_RESET && !$past(DEBUG_SERIAL_PIN_I, 100))
      else $error("probe without long low");
  a_timeout_idle:
    assert property (SOFT_RESET && !PROBE_SEEN |-> idle_cnt_q >= 16'h01F0)
      else $error("time-out before 512 idle cycles");
  a_hs_reset_off:
    assert property (disable iff (1'b0) !NRST |=> !HANDSHAKE_EN && DEBUG_SERIAL_PIN_OE_N)
      else $error("reset left handshake or drive on");
  a_reply_length:
    assert property ($rose(DEBUG_SERIAL_PIN_OE_N) |-> drv_cnt_q == 16'h0081)
      else $error("reply pulse length wrong");
  a_reply_shape:
    assert property (!DEBUG_SERIAL_PIN_OE_N |-> DEBUG_SERIAL_PIN_O == (drv_cnt_q == 16'h0080))
      else $error("reply low or speedup misplaced");
endmodule // dst_monitor
bind dst_debug_serial dst_monitor i_mon (.*);

// file: testbench/tb_top.sv
// self-checking bench for the debug serial time-out and step block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  reg  CORE_CLK = 0, NRST = 0, host_low = 0, CMD_PARTIAL = 0, CMD_VALID = 0, ACK_ISSUED = 0;
  reg  CMD_IS_ENTER_DEBUG = 0, CMD_IS_STEP = 0, CMD_IS_ACK_ENABLE = 0, CMD_IS_READ = 0;
  reg  DEBUG_MODE_ACTIVE = 0, IRQ_PENDING = 0, CPU_LOW_POWER = 0, SYSTEM_STOP = 0;
  reg  INSTR_DONE = 0, STACKING_DONE = 0, CMD_IS_ACK_DISABLE = 0, READ_DATA_FETCHED = 0;
  wire pin, DEBUG_SERIAL_PIN_O, DEBUG_SERIAL_PIN_OE_N, BIT_STROBE, BIT_VALUE, SOFT_RESET, PROBE_SEEN;
  wire CMD_EXEC, ACK_REQ, HANDSHAKE_EN, RUN_ONE_INSTR, DO_STACKING, ENTER_DEBUG_MODE, STEP_PENDING;
  integer errors = 0, compares = 0, bs, pr, sr, pr_at, sr_at, n, lo;
  always #12.5 CORE_CLK = ~CORE_CLK;
  dst_host_pod i_host (.tx_low(host_low), .oe_n(DEBUG_SERIAL_PIN_OE_N),
    .drv(DEBUG_SERIAL_PIN_O), .pin(pin));
  dst_debug_serial i_dut (.CE(1'b1), .DEBUG_SERIAL_PIN_I(pin), .*);
  task tick;
    @(posedge CORE_CLK);
    #1;
  endtask
  // run some cycles counting strobes, probes and soft resets
  task run(input integer cyc);
    integer i;
    bs = 0;
    pr = 0;
    sr = 0;
    for (i = 0; i < cyc; i++) begin
      tick;
      if (BIT_STROBE === 1'b1) bs++;
      if (PROBE_SEEN === 1'b1) begin
        pr++;
        pr_at = i;
      end
      if (SOFT_RESET === 1'b1) begin
        sr++;
        sr_at = i;
      end
    end
  endtask
  task cmd(input [3:0] k);
    tick;
    {CMD_IS_ENTER_DEBUG, CMD_IS_STEP, CMD_IS_ACK_ENABLE, CMD_IS_READ} = k;
    CMD_VALID = 1;
    tick;
    CMD_VALID = 0;
  endtask
  task t_bit;
    CMD_PARTIAL = 1;
    host_low = 1;
    run(20);
    `CHK("probe on short low", 0, pr)
    host_low = 0;
    run(600);
    `CHK("bit strobes", 1, bs)
    `CHK("bit value", 1'h1, BIT_VALUE)
    `CHK("soft resets", 1, sr)
    `CHK("time-out from fall", 1, sr_at + 21 >= 510 && sr_at + 21 <= 524)
    CMD_PARTIAL = 0;
    $display("test bit and time-out done");
  endtask
  task t_probe;
    host_low = 1;
    run(400);
    `CHK("probe seen", 1, pr)
    `CHK("probe after 128 low", 1, pr_at >= 127 && pr_at <= 136)
    `CHK("no reply while low", 1'h1, DEBUG_SERIAL_PIN_OE_N)
    host_low = 0;
    for (n = 0; n < 40 && DEBUG_SERIAL_PIN_OE_N !== 1'h0; n++) tick;
    `CHK("reply delay", 1, n >= 16 && n <= 26)
    for (lo = 0; lo < 200 && DEBUG_SERIAL_PIN_O === 1'h0; lo++) tick;
    `CHK("reply low length", 128, lo)
    `CHK("speedup", 2'h2, {DEBUG_SERIAL_PIN_O, DEBUG_SERIAL_PIN_OE_N})
    tick;
    `CHK("released", 1'h1, DEBUG_SERIAL_PIN_OE_N)
    $display("test probe done");
  endtask
  task t_step;
    DEBUG_MODE_ACTIVE = 1;
    cmd(4'h4);
    `CHK("one instruction", 2'h2, {RUN_ONE_INSTR, DO_STACKING})
    INSTR_DONE = 1;
    tick;
    INSTR_DONE = 0;
    `CHK("back in debug", 1'h1, ENTER_DEBUG_MODE)
    IRQ_PENDING = 1;
    cmd(4'h4); // steps with an interrupt pending, so only stacking runs
    `CHK("stacking only", 2'h1, {RUN_ONE_INSTR, DO_STACKING})
    STACKING_DONE = 1;
    tick;
    STACKING_DONE = 0;
    `CHK("debug at vector", 1'h1, ENTER_DEBUG_MODE)
    IRQ_PENDING = 0;
    $display("test step done");
  endtask
  task t_low_power;
    cmd(4'h2); // host enables the handshake
    `CHK("handshake on", 2'h3, {HANDSHAKE_EN, ACK_REQ})
    cmd(4'h4);
    DEBUG_MODE_ACTIVE = 0;
    CPU_LOW_POWER = 1;
    INSTR_DONE = 1;
    tick;
    INSTR_DONE = 0;
    `CHK("step held", 2'h2, {STEP_PENDING, ENTER_DEBUG_MODE})
    cmd(4'h8);
    `CHK("enter refused", 1'h0, CMD_EXEC)
    cmd(4'h2);
    `CHK("ack in low power", 2'h3, {CMD_EXEC, ACK_REQ})
    CPU_LOW_POWER = 0;
    STACKING_DONE = 1;
    tick;
    STACKING_DONE = 0;
    `CHK("debug after wake", 1'h1, ENTER_DEBUG_MODE)
    `CHK("step ack dropped", 1'h0, ACK_REQ)
    DEBUG_MODE_ACTIVE = 1;
    $display("test low power done");
  endtask
  task t_reads;
    cmd(4'h1);
    run(700);
    `CHK("read held with handshake", 0, sr)
    ACK_ISSUED = 1;
    tick;
    ACK_ISSUED = 0;
    run(560);
    `CHK("read dropped after ack", 1, sr)
    `CHK("ack re-arms 512", 1, sr_at >= 505 && sr_at <= 518)
    SYSTEM_STOP = 1;
    cmd(4'h2);
    `CHK("stop refuses, clears", 2'h0, {CMD_EXEC, HANDSHAKE_EN})
    SYSTEM_STOP = 0;
    cmd(4'h1);
    run(560);
    `CHK("read dropped without handshake", 1, sr)
    $display("test reads done");
  endtask
  task t_fetch;
    cmd(4'h2); // host re-enables the handshake after system stop
    `CHK("handshake back", 1'h1, HANDSHAKE_EN)
    cmd(4'h1);
    ACK_ISSUED = 1;
    tick;
    ACK_ISSUED = 0;
    run(300);
    `CHK("read kept before fetch", 0, sr)
    READ_DATA_FETCHED = 1;
    tick;
    READ_DATA_FETCHED = 0;
    run(600);
    `CHK("fetched read kept", 0, sr)
    CMD_IS_ACK_DISABLE = 1;
    cmd(4'h0);
    CMD_IS_ACK_DISABLE = 0;
    `CHK("ack disable acknowledged", 3'h6, {CMD_EXEC, ACK_REQ, HANDSHAKE_EN})
    $display("test fetch done");
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge CORE_CLK);
    #1 NRST = 1;
    repeat (4) tick;
    `CHK("handshake after reset", 1'h0, HANDSHAKE_EN)
    `CHK("pin free after reset", 1'h1, DEBUG_SERIAL_PIN_OE_N)
    t_bit;
    t_probe;
    t_step;
    t_low_power;
    t_reads;
    t_fetch;
    tally_and_finish;
  end
endmodule // tb_top
